// ### hw/pcstk.sv
// Program counter, return stack and indirect addressing unit.
// Assumes the execution unit issues at most one request per cycle and the
// memory arrays answer reads combinationally in the same cycle.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none

module pcstk (
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire pcstk_pkg::req_t REQ,
	input wire logic [7:0] PCL_WDATA,
	input wire pcstk_pkg::ind_req_t IND,
	input wire logic [15:0] FSR0,
	input wire logic [15:0] FSR1,
	input wire logic [7:0] DATA_RDATA,
	input wire logic [13:0] PROG_RDATA,
	input wire logic [13:0] CFG1_WORD,
	input wire logic [13:0] CFG2_WORD,
	output pcstk_pkg::mem_t MEM,
	output logic [7:0] IND_RDATA,
	output logic [14:0] PC,
	output logic [14:0] CFG_ADDR,
	output logic STACK_RESET,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [14:0] pc; // Program counter
		logic [6:0] page; // Page latch
		logic [4:0] sp; // Stack pointer
		logic ovf; // Overflow flag
		logic unf; // Underflow flag
		logic fault; // Stack fault reset pulse
		logic [13:0] cfg1; // Captured configuration words
		logic [13:0] cfg2;
		logic cfg_phase; // Configuration fetch step
		logic cfg_second; // Second configuration word next
		logic prog_wait; // Extra cycle for program memory
		logic aw_got, w_got; // Write channel captures
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} st_t;

	st_t s_r, s_nxt;
	logic [14:0] stack_r [pcstk_pkg::DEPTH]; // Return stack, own space
	logic push, pop, stk_wr; // Stack actions this cycle
	logic [3:0] wr_idx; // Entry written
	logic [14:0] wr_val; // Value written
	logic [14:0] tos; // Current top entry
	logic [15:0] fsr; // Selected indirect pointer
	logic [15:0] lin_off; // Offset inside linear region
	logic [6:0] lin_bank; // Bank index in linear region
	logic [6:0] lin_rem; // Offset inside the bank
	logic do_wr; // Bus write fires
	logic stvr; // Stack fault reset enable

	assign tos = stack_r[s_r.sp[3:0]];
	assign stvr = s_r.cfg2[pcstk_pkg::CFG2_STVR_BIT];
	assign fsr = IND.sel ? FSR1 : FSR0;
	assign lin_off = fsr - pcstk_pkg::LIN_BASE;
	// Division by a constant keeps the map exact; it is short logic
	assign lin_bank = 7'(lin_off / 16'(pcstk_pkg::BANK_GPR));
	assign lin_rem = 7'(lin_off % 16'(pcstk_pkg::BANK_GPR));

	// ==========================================================
	// Stack storage: the only multi-word memory of the block
	// Entries are not reset; the pointer starts empty, so a stale entry
	// is seen when software moves the pointer or a pop underflows the empty stack
	always_ff @(posedge CLK_SYS) begin
		if (stk_wr) begin
			stack_r[wr_idx] <= wr_val;
		end
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic [14:0] inc;
		logic [4:0] spn;
		inc = s_r.pc + 15'h0001;
		spn = s_r.sp;
		s_nxt = s_r;
		push = 1'b0;
		pop = 1'b0;
		stk_wr = 1'b0;
		wr_idx = s_r.sp[3:0];
		wr_val = s_r.pc;
		s_nxt.fault = 1'b0;
		MEM = '0;
		IND_RDATA = 8'h00;
		CFG_ADDR = 15'(pcstk_pkg::CFG1_ADDR);
		// Configuration words are read once after reset, one per cycle,
		// so the array only ever has to answer a single address
		if (s_r.cfg_phase && !s_r.cfg_second) begin
			// First step: word one, then point at word two
			s_nxt.cfg1 = CFG1_WORD;
			s_nxt.cfg_second = 1'b1;
		end else if (s_r.cfg_phase) begin
			// Second step: word two carries the fault reset enable
			CFG_ADDR = 15'(pcstk_pkg::CFG2_ADDR);
			s_nxt.cfg2 = CFG2_WORD;
			s_nxt.cfg_phase = 1'b0;
			s_nxt.cfg_second = 1'b0;
		end
		// Counter loading; the page latch is never changed here
		unique case (REQ.op)
			pcstk_pkg::OP_WRPCL: s_nxt.pc = {s_r.page, PCL_WDATA};
			pcstk_pkg::OP_CALL: begin
				s_nxt.pc = {s_r.page[6:3], REQ.operand};
				push = 1'b1;
			end
			pcstk_pkg::OP_COMPUTED_CALL: begin
				s_nxt.pc = {s_r.page, REQ.wreg};
				push = 1'b1;
			end
			pcstk_pkg::OP_BRW: s_nxt.pc = inc + {7'h00, REQ.wreg};
			pcstk_pkg::OP_BRA: begin
				// Sign-extend the nine-bit operand
				s_nxt.pc = inc + {{6{REQ.operand[8]}}, REQ.operand[8:0]};
			end
			pcstk_pkg::OP_IRQ: begin
				s_nxt.pc = REQ.vector;
				push = 1'b1;
			end
			pcstk_pkg::OP_RET, pcstk_pkg::OP_RETURN_WITH_LITERAL,
			pcstk_pkg::OP_RETURN_FROM_INTERRUPT: begin
				s_nxt.pc = tos; // Restore before decrement
				pop = 1'b1;
			end
			pcstk_pkg::OP_INC: s_nxt.pc = inc;
			pcstk_pkg::OP_NONE: ;
			default: ;
		endcase
		// Push: increment then write the return address
		if (push) begin
			spn = (s_r.sp == pcstk_pkg::SP_EMPTY) ? 5'h00 : s_r.sp + 5'h01;
			if (s_r.sp == pcstk_pkg::SP_TOP) begin
				s_nxt.ovf = 1'b1;
				s_nxt.fault = stvr;
				spn = stvr ? s_r.sp + 5'h01 : 5'h00; // Wraps otherwise
			end
			stk_wr = 1'b1;
			wr_idx = spn[3:0];
			wr_val = (REQ.op == pcstk_pkg::OP_IRQ) ? s_r.pc : inc;
		end
		// Pop: decrement after restore; empty reads 0x1F
		if (pop) begin
			spn = s_r.sp - 5'h01;
			if (s_r.sp == pcstk_pkg::SP_EMPTY) begin
				s_nxt.unf = 1'b1;
				s_nxt.fault = stvr;
				spn = stvr ? s_r.sp : pcstk_pkg::SP_TOP;
			end
		end
		s_nxt.sp = spn;
		// Indirect translation
		if (IND.valid && !s_r.prog_wait) begin
			if (fsr[15]) begin
				// Program memory: low byte only, writes dropped
				MEM.prog_en = !IND.wr;
				MEM.prog_addr = fsr[14:0];
				IND_RDATA = PROG_RDATA[7:0];
				MEM.stall = 1'b1; // One extra cycle
				s_nxt.prog_wait = 1'b1;
			end else if (fsr <= pcstk_pkg::TRAD_END) begin
				// Absolute data address self reference blocked
				if (fsr[6:0] == pcstk_pkg::INDF0_ADDR ||
					fsr[6:0] == pcstk_pkg::INDF1_ADDR) begin
					IND_RDATA = 8'h00;
				end else begin
					MEM.data_en = 1'b1;
					MEM.data_wr = IND.wr;
					MEM.data_addr = fsr[11:0];
					IND_RDATA = DATA_RDATA;
				end
			end else if (fsr >= pcstk_pkg::LIN_BASE &&
				fsr <= pcstk_pkg::LIN_END) begin
				// Bank chain skips the common bytes
				MEM.data_en = 1'b1;
				MEM.data_wr = IND.wr;
				MEM.data_addr = {lin_bank[4:0], lin_rem} +
					{5'h00, pcstk_pkg::GPR_OFS};
				IND_RDATA = DATA_RDATA;
			end
			// Anything else reads 0x00 and ignores writes
		end else if (IND.valid && s_r.prog_wait) begin
			MEM.prog_en = !IND.wr;
			MEM.prog_addr = fsr[14:0];
			IND_RDATA = PROG_RDATA[7:0];
			s_nxt.prog_wait = 1'b0;
		end
		// ======================================================
		// AXI4-Lite write channel, address and data in either order
		if (AWVALID && !s_r.aw_got) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = AWADDR;
		end
		if (WVALID && !s_r.w_got) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = WDATA;
		end
		do_wr = s_r.aw_got && s_r.w_got && !s_r.bvalid;
		if (do_wr) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = pcstk_pkg::RESP_OK;
			unique case (s_r.awaddr)
				pcstk_pkg::A_PAGE: s_nxt.page = s_r.wdata[6:0];
				pcstk_pkg::A_PCL:
					s_nxt.pc = {s_r.page, s_r.wdata[7:0]};
				pcstk_pkg::A_SP: s_nxt.sp = s_r.wdata[4:0];
				pcstk_pkg::A_TOP_ENTRY_LOW: begin
					stk_wr = 1'b1;
					wr_idx = s_r.sp[3:0];
					wr_val = {tos[14:8], s_r.wdata[7:0]};
				end
				pcstk_pkg::A_TOP_ENTRY_HIGH: begin
					stk_wr = 1'b1;
					wr_idx = s_r.sp[3:0];
					wr_val = {s_r.wdata[6:0], tos[7:0]};
				end
				pcstk_pkg::A_FLAGS: begin
					// Hardware set wins over software clear
					s_nxt.ovf = s_nxt.ovf & (s_r.wdata[pcstk_pkg::F_OVF] |
						(push && s_r.sp == pcstk_pkg::SP_TOP));
					s_nxt.unf = s_nxt.unf & (s_r.wdata[pcstk_pkg::F_UNF] |
						(pop && s_r.sp == pcstk_pkg::SP_EMPTY));
				end
				pcstk_pkg::A_CFG1, pcstk_pkg::A_CFG2: ;
				default: s_nxt.bresp = pcstk_pkg::RESP_ERR;
			endcase
		end
		if (s_r.bvalid && BREADY) begin
			s_nxt.bvalid = 1'b0;
		end
		// AXI4-Lite read channel
		if (ARVALID && !s_r.rvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = pcstk_pkg::RESP_OK;
			s_nxt.rdata = 32'h0000_0000;
			unique case (ARADDR)
				pcstk_pkg::A_PAGE: s_nxt.rdata[6:0] = s_r.page;
				pcstk_pkg::A_PCL: s_nxt.rdata[7:0] = s_r.pc[7:0];
				pcstk_pkg::A_SP: s_nxt.rdata[4:0] = s_r.sp;
				pcstk_pkg::A_TOP_ENTRY_LOW: s_nxt.rdata[7:0] = tos[7:0];
				pcstk_pkg::A_TOP_ENTRY_HIGH: s_nxt.rdata[6:0] = tos[14:8];
				pcstk_pkg::A_FLAGS: begin
					s_nxt.rdata[pcstk_pkg::F_OVF] = s_r.ovf;
					s_nxt.rdata[pcstk_pkg::F_UNF] = s_r.unf;
				end
				pcstk_pkg::A_CFG1: s_nxt.rdata[13:0] = s_r.cfg1;
				pcstk_pkg::A_CFG2: s_nxt.rdata[13:0] = s_r.cfg2;
				default: s_nxt.rresp = pcstk_pkg::RESP_ERR;
			endcase
		end else if (s_r.rvalid && RREADY) begin
			s_nxt.rvalid = 1'b0;
		end
	end

	// ==========================================================
	// State register; the fault pulse resets the core but keeps flags
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			s_r <= '0;
			s_r.sp <= pcstk_pkg::SP_EMPTY;
			s_r.cfg1 <= pcstk_pkg::CFG_BLANK;
			s_r.cfg2 <= pcstk_pkg::CFG_BLANK;
			// Configuration fetch restarts after every RESETN reset, not after a fault reset
			s_r.cfg_phase <= 1'b1;
		end else if (s_r.fault) begin
			s_r <= s_nxt;
			s_r.pc <= 15'h0000;
			s_r.sp <= pcstk_pkg::SP_EMPTY;
			s_r.prog_wait <= 1'b0;
		end else begin
			// Normal cycle: everything follows the next-state logic
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign PC = s_r.pc;
	assign STACK_RESET = s_r.fault;
	// Readies come straight from state; a captured channel keeps its
	// ready low until the write completes, so nothing is lost
	assign AWREADY = !s_r.aw_got;
	assign WREADY = !s_r.w_got;
	assign BVALID = s_r.bvalid;
	assign BRESP = s_r.bresp;
	assign ARREADY = !s_r.rvalid;
	assign RVALID = s_r.rvalid;
	assign RDATA = s_r.rdata;
	assign RRESP = s_r.rresp;
endmodule

`default_nettype wire

// ### include/pcstk_pkg.sv
// Package for the program counter, return stack and indirect address unit.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register master.
package pcstk_pkg;
	// ==========================================================
	// Widths and stack geometry
	localparam int PC_W = 15;
	localparam int DEPTH = 16;
	localparam logic [4:0] SP_EMPTY = 5'h1F;
	localparam logic [4:0] SP_TOP = 5'h0F;
	localparam logic [3:0] SP_IDX_W = 4'h0;
	// ==========================================================
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] A_PAGE = 8'h00;
	localparam logic [7:0] A_PCL = 8'h04;
	localparam logic [7:0] A_SP = 8'h08;
	localparam logic [7:0] A_TOP_ENTRY_LOW = 8'h0C;
	localparam logic [7:0] A_TOP_ENTRY_HIGH = 8'h10;
	localparam logic [7:0] A_FLAGS = 8'h14;
	localparam logic [7:0] A_CFG1 = 8'h18;
	localparam logic [7:0] A_CFG2 = 8'h1C;
	// Program-space addresses of the configuration words
	localparam logic [15:0] CFG1_ADDR = 16'h8007;
	localparam logic [15:0] CFG2_ADDR = 16'h8008;
	// Configuration word two: stack fault reset enable position
	localparam int CFG2_STVR_BIT = 9;
	localparam logic [13:0] CFG_BLANK = 14'h3FFF;
	// Flag register bit positions
	localparam int F_OVF = 7;
	localparam int F_UNF = 6;
	// ==========================================================
	// Indirect address map
	localparam logic [15:0] TRAD_END = 16'h0FFF;
	localparam logic [15:0] LIN_BASE = 16'h2000;
	localparam logic [15:0] LIN_END = 16'h29AF;
	localparam logic [6:0] BANK_GPR = 7'h50;
	localparam logic [6:0] GPR_OFS = 7'h20;
	localparam logic [6:0] INDF0_ADDR = 7'h00;
	localparam logic [6:0] INDF1_ADDR = 7'h01;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// Operations asked by the execution unit
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_WRPCL = 4'h1, OP_CALL = 4'h2, OP_COMPUTED_CALL = 4'h3,
		OP_BRW = 4'h4, OP_BRA = 4'h5, OP_RET = 4'h6, OP_RETURN_WITH_LITERAL = 4'h7,
		OP_RETURN_FROM_INTERRUPT = 4'h8, OP_IRQ = 4'h9, OP_INC = 4'hA
	} op_t;

	// Request from the execution unit
	typedef struct packed {
		op_t op;
		logic [10:0] operand;
		logic [7:0] wreg;
		logic [PC_W-1:0] vector;
	} req_t;

	// Indirect access request
	typedef struct packed {
		logic valid;
		logic wr;
		logic sel;
		logic [7:0] wdata;
	} ind_req_t;

	// Translated memory access
	typedef struct packed {
		logic data_en;
		logic data_wr;
		logic [11:0] data_addr;
		logic prog_en;
		logic [PC_W-1:0] prog_addr;
		logic stall;
	} mem_t;
endpackage

// ### testbench/pcstk_mem.sv
// Model of the data and program arrays and the configuration words.
// Assumes the unit reads combinationally and writes at the clock edge.
`timescale 1ns/1ps
`default_nettype none
module pcstk_mem #(
	parameter logic [13:0] CFG1_VAL = 14'h2B6D // Arbitrary word
) (
	input wire logic clk,
	input wire pcstk_pkg::mem_t mem,
	input wire logic [7:0] wdata,
	input wire logic stvr,
	input wire logic [14:0] cfg_addr,
	output logic [7:0] data_rdata,
	output logic [13:0] prog_rdata,
	output logic [13:0] cfg1_word,
	output logic [13:0] cfg2_word
);
	logic [7:0] ram [0:4095]; // Filled with a non-zero mark
	logic [13:0] pword; // Program word pattern
	logic [13:0] cfg2_val; // Fault reset bit set on demand
	initial begin
		for (int i = 0; i < 4096; i++) ram[i] = 8'hEE;
	end
	// Write port; a disabled array never changes
	always @(posedge clk) begin
		if (mem.data_en && mem.data_wr) begin
			ram[mem.data_addr] <= wdata;
		end
	end
	// Idle outputs show inverted data so stale reads cannot pass
	assign pword = mem.prog_addr[13:0] ^ 14'h01C3;
	assign data_rdata = mem.data_en ? ram[mem.data_addr] : ~ram[mem.data_addr];
	assign prog_rdata = mem.prog_en ? pword : ~pword;
	assign cfg2_val = stvr ? 14'h3FFF : 14'h3DFF;
	assign cfg1_word = cfg_addr == pcstk_pkg::CFG1_ADDR[14:0] ? CFG1_VAL : ~CFG1_VAL;
	assign cfg2_word = cfg_addr == pcstk_pkg::CFG2_ADDR[14:0] ? cfg2_val : ~cfg2_val;
endmodule
`default_nettype wire

// ### testbench/pcstk_sva.sv
// Checker for the counter, return stack and indirect address unit.
// Assumes it is bound to pcstk and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module pcstk_sva (
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire pcstk_pkg::req_t REQ,
	input wire logic [7:0] PCL_WDATA,
	input wire pcstk_pkg::ind_req_t IND,
	input wire logic [15:0] FSR0,
	input wire logic [15:0] FSR1,
	input wire pcstk_pkg::mem_t MEM,
	input wire logic [7:0] IND_RDATA,
	input wire logic [14:0] PC,
	input wire logic STACK_RESET
);
	// ==========================================================
	// Pointer decode, worked out apart from the design
	logic [15:0] fsel; // Pointer picked by the request
	logic [15:0] loff; // Offset into the linear window
	logic [15:0] lin_exp; // Banked address expected
	logic self_ref; // Pointer names an indirect port
	assign fsel = IND.sel ? FSR1 : FSR0;
	assign loff = fsel - 16'h2000;
	assign lin_exp = (loff / 16'h0050) * 16'h0080 + 16'h0020 + loff % 16'h0050;
	assign self_ref = fsel <= 16'h0FFF && fsel[6:0] <= 7'h01;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	// ==========================================================
	// Fault reset: one pulse, then the counter restarts
	sequence s_fault;
		STACK_RESET ##1 (PC == 15'h0000 && !STACK_RESET);
	endsequence
	sequence s_stall;
		MEM.stall ##1 !MEM.stall;
	endsequence
	chk_reset_clear: assert property ($rose(RESETN) |-> PC == 15'h0000)
		else $error("counter not cleared by reset");
	chk_pcl_load: assert property (REQ.op == pcstk_pkg::OP_WRPCL |=> PC[7:0] == $past(PCL_WDATA))
		else $error("low byte write not loaded");
	chk_call_low: assert property (REQ.op == pcstk_pkg::OP_CALL |=> PC[10:0] == $past(REQ.operand))
		else $error("call target wrong");
	chk_brw_sum: assert property (REQ.op == pcstk_pkg::OP_BRW |=> PC == $past(PC) + 15'h0001 + {7'h00, $past(REQ.wreg)})
		else $error("register branch target wrong");
	chk_ind_self: assert property (IND.valid && self_ref |-> (IND.wr || IND_RDATA == 8'h00) && !MEM.data_wr)
		else $error("self indirect access not blocked");
	chk_trad_map: assert property (IND.valid && fsel <= 16'h0FFF && !self_ref |-> MEM.data_en && MEM.data_addr == fsel[11:0])
		else $error("traditional address wrong");
	chk_lin_map: assert property (IND.valid && fsel >= 16'h2000 && fsel <= 16'h29AF |-> MEM.data_en && MEM.data_addr == lin_exp[11:0])
		else $error("linear address wrong");
	chk_prog_ro: assert property (IND.valid && fsel[15] |-> MEM.prog_en == !IND.wr && MEM.prog_addr == fsel[14:0] && !MEM.data_wr)
		else $error("program access wrong");
	chk_prog_stall: assert property (IND.valid && fsel[15] && !$past(IND.valid) |-> s_stall)
		else $error("program access not one cycle longer");
	chk_fault_pulse: assert property (STACK_RESET |-> s_fault)
		else $error("stack fault reset wrong");
endmodule
`default_nettype wire

// ### testbench/pcstk_test.sv
// Self-checking bench for the counter, stack and indirect unit.
// Assumes pcstk, its package, the checker and the array model.
`timescale 1ns/1ps
`default_nettype none
module pcstk_test;
	logic clk, rstn, stvr, awvalid, wvalid, bready, arvalid, rready;
	pcstk_pkg::req_t req;
	pcstk_pkg::ind_req_t ind;
	pcstk_pkg::mem_t mem;
	logic [7:0] pcl_wd, ind_rd, awaddr, araddr, data_rd;
	logic [15:0] fsr0, fsr1;
	logic [13:0] prog_rd, cfg1, cfg2;
	logic [14:0] pc, cfg_addr;
	logic stk_rst, awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, last_bresp;
	logic [7:0] d;
	int miscompares = 0;
	int check_count = 0;
	pcstk dut (.CLK_SYS(clk), .RESETN(rstn), .REQ(req), .PCL_WDATA(pcl_wd),
		.IND(ind), .FSR0(fsr0), .FSR1(fsr1), .DATA_RDATA(data_rd),
		.PROG_RDATA(prog_rd), .CFG1_WORD(cfg1), .CFG2_WORD(cfg2), .MEM(mem),
		.IND_RDATA(ind_rd), .PC(pc), .CFG_ADDR(cfg_addr), .STACK_RESET(stk_rst),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
		.WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(rready));
	pcstk_mem u_mem (.clk(clk), .mem(mem), .wdata(ind.wdata), .stvr(stvr),
		.cfg_addr(cfg_addr), .data_rdata(data_rd), .prog_rdata(prog_rd),
		.cfg1_word(cfg1), .cfg2_word(cfg2));
	// ==========================================================
	// Shared checks and bus cycles
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 40) miscompares++;
		last_bresp = bresp;
		bready <= 1'b0;
		#1;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 40) miscompares++;
		v = rdata;
		r = rresp;
		rready <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0] r;
		axi_rd(a, v, r);
		chk(v, e);
	endtask
	// One request, taken at the next edge, then idle
	task automatic op(input pcstk_pkg::op_t o, input logic [10:0] x, input logic [7:0] w);
		@(posedge clk);
		req <= {o, x, w, 4'h0, x};
		@(posedge clk);
		req.op <= pcstk_pkg::OP_NONE;
		#1;
	endtask
	// Program accesses hold the request for two cycles
	task automatic ind_acc(input logic s, input logic w, input logic [7:0] v, input logic p);
		@(posedge clk);
		ind <= {1'b1, w, s, v};
		#1;
		if (p) begin
			chk(mem.stall, 1'b1);
			@(posedge clk);
			#1;
			chk(mem.stall, 1'b0);
		end
		d = ind_rd;
		@(posedge clk);
		ind.valid <= 1'b0;
		#1;
	endtask
	// Held six cycles, then three more until fault resets are armed
	task automatic rst();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [31:0] v;
		logic [1:0] r;
		rst();
		chk(pc, 15'h0000);
		rd_chk(pcstk_pkg::A_SP, 32'h1F);
		rd_chk(pcstk_pkg::A_CFG1, 32'h2B6D);
		rd_chk(pcstk_pkg::A_CFG2, 32'h3DFF);
		axi_rd(8'hF0, v, r);
		chk({30'h0, r}, {30'h0, pcstk_pkg::RESP_ERR});
		axi_wr(pcstk_pkg::A_PAGE, 32'h55);
		axi_wr(pcstk_pkg::A_PCL, 32'h12);
		chk(pc, 15'h5512);
		chk({30'h0, last_bresp}, {30'h0, pcstk_pkg::RESP_OK});
		axi_wr(8'hF0, 32'h0000_0000);
		chk({30'h0, last_bresp}, {30'h0, pcstk_pkg::RESP_ERR});
		pcl_wd = 8'h34;
		op(pcstk_pkg::OP_WRPCL, 11'h000, 8'h00);
		chk(pc, 15'h5534);
		$display("test regs done");
	endtask
	task automatic t_flow();
		op(pcstk_pkg::OP_CALL, 11'h3A5, 8'h00);
		chk(pc, 15'h53A5);
		rd_chk(pcstk_pkg::A_SP, 32'h00);
		rd_chk(pcstk_pkg::A_TOP_ENTRY_LOW, 32'h35);
		rd_chk(pcstk_pkg::A_TOP_ENTRY_HIGH, 32'h55);
		op(pcstk_pkg::OP_COMPUTED_CALL, 11'h000, 8'h77);
		chk(pc, 15'h5577);
		rd_chk(pcstk_pkg::A_SP, 32'h01);
		op(pcstk_pkg::OP_BRW, 11'h000, 8'hF0);
		chk(pc, 15'h5668);
		op(pcstk_pkg::OP_BRA, 11'h7FF, 8'h00);
		chk(pc, 15'h5668);
		op(pcstk_pkg::OP_BRA, 11'h005, 8'h00);
		chk(pc, 15'h566E);
		op(pcstk_pkg::OP_RET, 11'h000, 8'h00);
		chk(pc, 15'h53A6);
		op(pcstk_pkg::OP_RETURN_WITH_LITERAL, 11'h000, 8'h00);
		chk(pc, 15'h5535);
		rd_chk(pcstk_pkg::A_SP, 32'h1F);
		rd_chk(pcstk_pkg::A_PAGE, 32'h55);
		$display("test flow done");
	endtask
	// Seventeen pushes with the fault reset off wrap onto entry 0
	task automatic t_wrap();
		rst();
		for (int i = 0; i < 17; i++) op(pcstk_pkg::OP_IRQ, 11'h100 + 11'(i), 8'h00);
		rd_chk(pcstk_pkg::A_FLAGS, 32'h80);
		rd_chk(pcstk_pkg::A_SP, 32'h00);
		rd_chk(pcstk_pkg::A_TOP_ENTRY_LOW, 32'h0F);
		op(pcstk_pkg::OP_RETURN_FROM_INTERRUPT, 11'h000, 8'h00);
		chk(pc, 15'h010F);
		op(pcstk_pkg::OP_RET, 11'h000, 8'h00);
		rd_chk(pcstk_pkg::A_FLAGS, 32'hC0);
		rd_chk(pcstk_pkg::A_SP, 32'h0F);
		axi_wr(pcstk_pkg::A_FLAGS, 32'h00);
		rd_chk(pcstk_pkg::A_FLAGS, 32'h00);
		$display("test wrap done");
	endtask
	task automatic t_fault();
		stvr = 1'b1;
		rst();
		for (int i = 0; i < 17; i++) op(pcstk_pkg::OP_IRQ, 11'h200 + 11'(i), 8'h00);
		chk(stk_rst, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk(pc, 15'h0000);
		rd_chk(pcstk_pkg::A_SP, 32'h1F);
		op(pcstk_pkg::OP_RET, 11'h000, 8'h00);
		chk(stk_rst, 1'b1);
		repeat (2) @(posedge clk);
		rd_chk(pcstk_pkg::A_FLAGS, 32'hC0);
		$display("test fault done");
	endtask
	task automatic t_ind();
		fsr0 = 16'h0123;
		fsr1 = 16'h0123;
		ind_acc(1'b0, 1'b1, 8'hA5, 1'b0);
		ind_acc(1'b1, 1'b0, 8'h00, 1'b0);
		chk(d, 8'hA5);
		fsr0 = 16'h2050;
		fsr1 = 16'h00A0;
		ind_acc(1'b0, 1'b1, 8'h5A, 1'b0);
		ind_acc(1'b1, 1'b0, 8'h00, 1'b0);
		chk(d, 8'h5A);
		fsr0 = 16'h29AF;
		fsr1 = 16'h0F6F;
		ind_acc(1'b0, 1'b1, 8'h6C, 1'b0);
		ind_acc(1'b1, 1'b0, 8'h00, 1'b0);
		chk(d, 8'h6C);
		fsr0 = 16'h0001;
		fsr1 = 16'h0080;
		ind_acc(1'b0, 1'b1, 8'h33, 1'b0);
		ind_acc(1'b1, 1'b0, 8'h00, 1'b0);
		chk(d, 8'h00);
		fsr0 = 16'h8040;
		fsr1 = 16'h8123;
		ind_acc(1'b0, 1'b1, 8'h99, 1'b1);
		ind_acc(1'b1, 1'b0, 8'h00, 1'b1);
		chk(d, 8'hE0);
		$display("test indirect done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog well beyond the few hundred cycles needed
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end
	initial begin
		{rstn, stvr, awvalid, wvalid, bready, arvalid, rready} = '0;
		req = '0;
		ind = '0;
		{pcl_wd, awaddr, araddr, fsr0, fsr1, wdata} = '0;
		t_regs();
		t_flow();
		t_wrap();
		t_fault();
		t_ind();
		give_verdict();
	end
endmodule
bind pcstk pcstk_sva u_sva (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .REQ(REQ),
	.PCL_WDATA(PCL_WDATA), .IND(IND), .FSR0(FSR0), .FSR1(FSR1), .MEM(MEM),
	.IND_RDATA(IND_RDATA), .PC(PC), .STACK_RESET(STACK_RESET));
`default_nettype wire
